// ===== verilog/apcp_device.sv
/*
 holds the device end of the configuration port and its byte fifo.
 assumes pins arrive from an asynchronous host; the core drains bytes.
*/
`timescale 1ns/1ps

// ==========================================================
// byte fifo
module apcp_fifo #(
    parameter int WIDTH = apcp_pkg::BYTE_W,
    parameter int DEPTH = apcp_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,              // core clock
    input wire logic rst,                   // async reset
    input wire logic [WIDTH-1:0] in_data,   // write data
    input wire logic in_valid,              // write request
    output logic in_ready,                  // space available
    output logic [WIDTH-1:0] out_data,      // head data
    output logic out_valid,                 // head valid
    input wire logic out_ready              // head taken
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            count <= CW'(count + CW'(push) - CW'(pop));
        end
    end
endmodule : apcp_fifo

// ==========================================================
// device end
module apcp_device #(
    parameter int CLEAR_CYCLES = apcp_pkg::CLEAR_CYCLES,
    parameter int CONFIG_BYTES = apcp_pkg::CONFIG_BYTES,
    parameter int FIFO_DEPTH = apcp_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,              // core clock
    input wire logic rst,                   // async reset
    apcp_if.device pins,                    // host-facing pins
    output logic [7:0] cfg_byte,            // byte to config memory
    output logic cfg_valid,                 // byte available
    input wire logic cfg_ready,             // config memory takes byte
    input wire logic scan_selected,         // boundary scan chosen
    output logic scan_enable,               // scan functions live
    output logic scan_reset,                // scan circuitry reset
    output logic select_pins_released,      // selects now user io
    output logic [2:0] latched_mode,        // mode taken at init rise
    output logic config_complete            // configuration finished
);
    typedef enum {ST_CLEAR, ST_WAIT, ST_LOAD, ST_START, ST_USER} apcp_dev_state_t;
    localparam int NS = 18;
    apcp_dev_state_t state;
    logic [NS-1:0] s1, s2, s3, filt;
    logic f_reprogram_n_n, f_init_n, f_done, f_sel_lo_n, f_sel_hi, f_wr_n, f_rd_n;
    logic [7:0] f_d;
    logic [2:0] f_mode;
    logic [apcp_pkg::CNT_W-1:0] clear_cnt;
    logic [apcp_pkg::CNT_W-1:0] drained;
    logic init_prev;
    logic wr_prev;
    logic pending;
    logic [7:0] byte_buf;
    logic fifo_in_ready;
    logic selected;
    logic wr_act;
    logic rd_act;
    logic restart;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
            filt <= '1;
        end else begin
            s1 <= {pins.reprogram_n, pins.init_n, pins.done, pins.select_low_n, pins.select_high,
                   pins.wr_n, pins.rd_n, pins.d, pins.config_mode_select};
            s2 <= s1;
            s3 <= s2;
            filt <= NS'(apcp_pkg::apcp_agree(32'(s2), 32'(s3), 32'(filt)));
        end
    end
    assign {f_reprogram_n_n, f_init_n, f_done, f_sel_lo_n, f_sel_hi, f_wr_n, f_rd_n, f_d, f_mode} = filt;

    assign restart = !f_reprogram_n_n;
    assign selected = !f_sel_lo_n && f_sel_hi && (state == ST_LOAD)
                      && (latched_mode == apcp_pkg::MODE_ASYNC_PERIPH);
    assign wr_act = selected && !f_wr_n;
    assign rd_act = selected && !f_rd_n && f_wr_n;

    // ==========================================================
    // configuration sequence
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_CLEAR;
            clear_cnt <= '0;
            init_prev <= 1'b1;
            latched_mode <= '0;
        end else if (restart) begin
            state <= ST_CLEAR;
            clear_cnt <= '0;
            init_prev <= 1'b1;
        end else begin
            init_prev <= f_init_n;
            case (state)
                ST_CLEAR: begin
                    clear_cnt <= apcp_pkg::CNT_W'(clear_cnt + 1'b1);
                    if (clear_cnt == apcp_pkg::CNT_W'(CLEAR_CYCLES - 1)) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (f_init_n && !init_prev) begin
                        latched_mode <= f_mode;
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (drained == apcp_pkg::CNT_W'(CONFIG_BYTES)) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (f_done) begin
                        state <= ST_USER;
                    end
                end
                ST_USER: begin
                    state <= ST_USER;
                end
                default: begin
                    state <= ST_CLEAR;
                end
            endcase
        end
    end

    // ==========================================================
    // write capture and byte buffer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_prev <= 1'b0;
            pending <= 1'b0;
            byte_buf <= '0;
        end else if (restart || state != ST_LOAD) begin
            wr_prev <= 1'b0;
            pending <= 1'b0;
        end else begin
            wr_prev <= wr_act;
            if (wr_act && !wr_prev && !pending && fifo_in_ready) begin
                byte_buf <= f_d;
                pending <= 1'b1;
            end else if (pending && fifo_in_ready) begin
                pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drained <= '0;
        end else if (restart || state == ST_WAIT) begin
            drained <= '0;
        end else if (cfg_valid && cfg_ready && state == ST_LOAD) begin
            drained <= apcp_pkg::CNT_W'(drained + 1'b1);
        end
    end

    apcp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_data(byte_buf),
        .in_valid(pending),
        .in_ready(fifo_in_ready),
        .out_data(cfg_byte),
        .out_valid(cfg_valid),
        .out_ready(cfg_ready)
    );

    // ==========================================================
    // pin outputs
    assign pins.ready_out = (state == ST_LOAD) && fifo_in_ready && !pending && !wr_act;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins.dev_d7_oe <= 1'b0;
            pins.data_bit_seven <= 1'b0;
        end else begin
            pins.dev_d7_oe <= rd_act;
            pins.data_bit_seven <= pins.ready_out;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins.config_busy_high_out <= 1'b1;
            pins.config_busy_low_out <= 1'b0;
            pins.dev_init_oe <= 1'b1;
            pins.dev_done_oe <= 1'b1;
            config_complete <= 1'b0;
            select_pins_released <= 1'b0;
        end else begin
            pins.config_busy_high_out <= (state != ST_USER) || restart;
            pins.config_busy_low_out <= (state == ST_USER) && !restart;
            pins.dev_init_oe <= (state == ST_CLEAR) || restart;
            pins.dev_done_oe <= !(state == ST_START || state == ST_USER) || restart;
            config_complete <= (state == ST_USER) && !restart;
            select_pins_released <= (state == ST_USER) && !restart;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scan_enable <= 1'b1;
            scan_reset <= 1'b1;
        end else begin
            scan_enable <= (state != ST_USER) || scan_selected;
            scan_reset <= restart;
        end
    end
endmodule : apcp_device

// ===== verilog/apcp_pkg.sv
/*
 holds the shared constants of the asynchronous peripheral configuration port.
 assumes a single 100 MHz core clock on both ends.
*/
package apcp_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLEAR_NS = 2000;
    localparam int CLEAR_CYCLES = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_SETUP_NS = 20;
    localparam int WR_SETUP_CYCLES = (WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_LOW_NS = 80;
    localparam int WR_LOW_CYCLES = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_NS = 100;
    localparam int RECOVER_CYCLES = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_NS = 100;
    localparam int READ_CYCLES = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REPROGRAM_N_NS = 100;
    localparam int REPROGRAM_N_CYCLES = (REPROGRAM_N_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // ==========================================================
    // modes and sizes
    localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int CONFIG_BYTES = 64;
    localparam logic [BYTE_W-1:0] BUS_PULLUP = 8'hFF;
    // ==========================================================
    // pin filter: a bit changes once the second and third stages agree
    function automatic logic [31:0] apcp_agree(input logic [31:0] s2, input logic [31:0] s3,
                                               input logic [31:0] old);
        apcp_agree = (s2 & s3) | (old & (s2 | s3));
    endfunction : apcp_agree
endpackage : apcp_pkg

// ===== verilog/apcp_if.sv
/*
 holds the pin bundle between the configuring host and the device port.
 assumes open-drain and pulled-up lines resolve here from the enables.
*/
`timescale 1ns/1ps
interface apcp_if;
    logic select_low_n;                 // chip select, active low
    logic select_high;                  // chip select, active high
    logic wr_n;                         // write strobe
    logic rd_n;                         // read strobe
    logic [7:0] host_d;                 // host data drive
    logic host_d_oe;                    // host drives data
    logic data_bit_seven;               // device status drive
    logic dev_d7_oe;                    // device drives bit seven
    logic [7:0] d;                      // resolved data bus
    logic ready_out;                    // byte can be written
    logic config_busy_high_out;         // high while configuring
    logic config_busy_low_out;          // low while configuring
    logic dev_init_oe;                  // device pulls init low
    logic host_init_oe;                 // host pulls init low
    logic init_n;                       // resolved init line
    logic dev_done_oe;                  // device pulls done low
    logic host_done_oe;                 // host pulls done low
    logic done;                         // resolved done line
    logic reprogram_n;                  // restart configuration
    logic [2:0] config_mode_select;     // mode straps
    logic tck;                          // test clock
    logic tms;                          // test mode select
    logic tdi;                          // test data in

    // ==========================================================
    // wire resolution with pull-ups
    assign d[7] = dev_d7_oe ? data_bit_seven : (host_d_oe ? host_d[7] : apcp_pkg::BUS_PULLUP[7]);
    assign d[6:0] = host_d_oe ? host_d[6:0] : apcp_pkg::BUS_PULLUP[6:0];
    assign init_n = ~(dev_init_oe | host_init_oe);
    assign done = ~(dev_done_oe | host_done_oe);

    modport device (
        input select_low_n, select_high, wr_n, rd_n, d, init_n, done, reprogram_n, config_mode_select,
        output data_bit_seven, dev_d7_oe, ready_out, config_busy_high_out, config_busy_low_out,
        output dev_init_oe, dev_done_oe
    );
    modport host (
        output select_low_n, select_high, wr_n, rd_n, host_d, host_d_oe, host_init_oe, host_done_oe,
        output reprogram_n, config_mode_select, tck, tms, tdi,
        input d, ready_out, config_busy_high_out, config_busy_low_out, init_n, done
    );
endinterface : apcp_if

// ===== verilog/apcp_host.sv
/*
 holds the host end that loads configuration bytes over the strobe port.
 assumes the device pins resolve in the interface; user feeds bytes.
*/
`timescale 1ns/1ps
module apcp_host #(
    parameter logic [2:0] MODE = apcp_pkg::MODE_ASYNC_PERIPH
) (
    input wire logic core_clk,              // core clock
    input wire logic rst,                   // async reset
    apcp_if.host pins,                      // device-facing pins
    input wire logic [7:0] byte_data,       // byte to send
    input wire logic byte_valid,            // byte offered
    output logic byte_ready,                // byte taken
    input wire logic status_req,            // read status pulse
    output logic status_valid,              // status sample pulse
    output logic status_bit,                // sampled bit seven
    input wire logic restart_req,           // pulse program low
    input wire logic hold_init,             // keep device waiting
    input wire logic hold_done,             // delay device start
    output logic device_busy,               // busy-high seen
    output logic device_done                // done line seen high
);
    typedef enum {H_IDLE, H_SETUP, H_STROBE, H_RECOVER, H_READ} apcp_host_state_t;
    localparam int NS = 5;
    apcp_host_state_t state;
    logic [NS-1:0] s1, s2, s3, filt;
    logic f_ready, f_busy, f_done, f_d7;
    logic [apcp_pkg::CNT_W-1:0] cnt;
    logic [apcp_pkg::CNT_W-1:0] reprogram_n_cnt;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end else begin
            s1 <= {pins.ready_out, pins.config_busy_high_out, pins.done, pins.d[7], 1'b0};
            s2 <= s1;
            s3 <= s2;
            filt <= NS'(apcp_pkg::apcp_agree(32'(s2), 32'(s3), 32'(filt)));
        end
    end
    assign {f_ready, f_busy, f_done, f_d7} = filt[NS-1:1];
    assign byte_ready = (state == H_IDLE) && f_ready && !status_req;

    // ==========================================================
    // strobe sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= H_IDLE;
            cnt <= '0;
            pins.select_low_n <= 1'b1;
            pins.select_high <= 1'b0;
            pins.wr_n <= 1'b1;
            pins.rd_n <= 1'b1;
            pins.host_d <= '0;
            pins.host_d_oe <= 1'b0;
            status_valid <= 1'b0;
            status_bit <= 1'b0;
        end else begin
            status_valid <= 1'b0;
            case (state)
                H_IDLE: begin
                    cnt <= '0;
                    if (status_req) begin
                        pins.select_low_n <= 1'b0;
                        pins.select_high <= 1'b1;
                        pins.rd_n <= 1'b0;
                        state <= H_READ;
                    end else if (byte_valid && byte_ready) begin
                        pins.select_low_n <= 1'b0;
                        pins.select_high <= 1'b1;
                        pins.host_d <= byte_data;
                        pins.host_d_oe <= 1'b1;
                        state <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    cnt <= apcp_pkg::CNT_W'(cnt + 1'b1);
                    if (cnt == apcp_pkg::CNT_W'(apcp_pkg::WR_SETUP_CYCLES - 1)) begin
                        cnt <= '0;
                        pins.wr_n <= 1'b0;
                        state <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    cnt <= apcp_pkg::CNT_W'(cnt + 1'b1);
                    if (cnt == apcp_pkg::CNT_W'(apcp_pkg::WR_LOW_CYCLES - 1)) begin
                        cnt <= '0;
                        pins.wr_n <= 1'b1;
                        state <= H_RECOVER;
                    end
                end
                H_RECOVER: begin
                    cnt <= apcp_pkg::CNT_W'(cnt + 1'b1);
                    pins.select_low_n <= 1'b1;
                    pins.select_high <= 1'b0;
                    pins.host_d_oe <= 1'b0;
                    if (cnt == apcp_pkg::CNT_W'(apcp_pkg::RECOVER_CYCLES - 1)) begin
                        state <= H_IDLE;
                    end
                end
                H_READ: begin
                    cnt <= apcp_pkg::CNT_W'(cnt + 1'b1);
                    if (cnt == apcp_pkg::CNT_W'(apcp_pkg::READ_CYCLES - 1)) begin
                        status_bit <= f_d7;
                        status_valid <= 1'b1;
                        pins.rd_n <= 1'b1;
                        cnt <= '0;
                        state <= H_RECOVER;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // program, init, done and test pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reprogram_n_cnt <= '0;
            pins.reprogram_n <= 1'b1;
        end else if (restart_req) begin
            reprogram_n_cnt <= apcp_pkg::CNT_W'(apcp_pkg::REPROGRAM_N_CYCLES);
            pins.reprogram_n <= 1'b0;
        end else if (reprogram_n_cnt != '0) begin
            reprogram_n_cnt <= apcp_pkg::CNT_W'(reprogram_n_cnt - 1'b1);
            pins.reprogram_n <= (reprogram_n_cnt == apcp_pkg::CNT_W'(1));
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins.host_init_oe <= 1'b0;
            pins.host_done_oe <= 1'b0;
            pins.config_mode_select <= '0;
            pins.tck <= 1'b0;
            pins.tms <= 1'b1;
            pins.tdi <= 1'b0;
            device_busy <= 1'b0;
            device_done <= 1'b0;
        end else begin
            pins.host_init_oe <= hold_init;
            pins.host_done_oe <= hold_done;
            pins.config_mode_select <= MODE;
            device_busy <= f_busy;
            device_done <= f_done;
        end
    end
endmodule : apcp_host

// ===== sim/apcp_checker.sv
/* pin checker of the configuration port.
 assumes the bench ties it beside the interface joining both ends. */
`timescale 1ns/1ps
module apcp_checker (
    input wire logic core_clk, // core clock
    input wire logic rst, // async reset
    input wire logic wr_n, // write strobe
    input wire logic rd_n, // read strobe
    input wire logic select_low_n, // select, low
    input wire logic select_high, // select, high
    input wire logic data_bit_seven, // status drive
    input wire logic dev_d7_oe, // status enable
    input wire logic ready_out, // byte can go
    input wire logic config_busy_high_out, // busy high
    input wire logic config_busy_low_out, // busy low
    input wire logic dev_init_oe, // device pulls init
    input wire logic init_n, // init line
    input wire logic done, // done line
    input wire logic reprogram_n // restart
);
    // ==========================================================
    // properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_sel_write;
        $fell(wr_n) && !select_low_n && select_high && ready_out;
    endsequence
    sequence s_prog_low;
        $fell(reprogram_n) ##1 !reprogram_n;
    endsequence
    chk_busy_pair: assert property (config_busy_high_out != config_busy_low_out)
        else $error("busy indicators not complementary");
    chk_init_clear: assert property ($fell(rst) |-> dev_init_oe [*3])
        else $error("init not held during clearing");
    chk_ready_init: assert property (!init_n |-> !ready_out)
        else $error("ready while init low");
    chk_d7_read: assert property ($rose(dev_d7_oe) |-> !rd_n && wr_n && !select_low_n && select_high)
        else $error("status driven without selected read");
    chk_d7_status: assert property (dev_d7_oe && $past(dev_d7_oe) && $stable(ready_out) |-> data_bit_seven == ready_out)
        else $error("status bit differs from ready");
    chk_write_busy: assert property (s_sel_write |-> ##[1:8] !ready_out)
        else $error("ready stayed high after write");
    chk_done_busy: assert property ($rose(done) |-> ##[1:8] !config_busy_high_out)
        else $error("busy stayed after done");
    chk_busy_done: assert property ($fell(config_busy_high_out) |-> done)
        else $error("busy cleared with done low");
    chk_restart_clear: assert property (s_prog_low |-> ##[1:8] (config_busy_high_out && dev_init_oe))
        else $error("restart did not clear");
endmodule : apcp_checker

// ===== sim/apcp_tb_top.sv
/* bench joining host and device ends of the configuration port.
 assumes one core clock; a small config count keeps the run short. */
`timescale 1ns/1ps
module apcp_tb_top;
    localparam int NB = 36;
    logic core_clk = 1'b0, rst = 1'b1, byte_valid = 1'b0, status_req = 1'b0, restart_req = 1'b0;
    logic hold_init = 1'b1, hold_done = 1'b0, cfg_ready = 1'b0, scan_sel = 1'b0;
    logic [7:0] byte_data = 8'h00, cfg_byte;
    logic byte_ready, status_valid, status_bit, device_busy, device_done, cfg_valid;
    logic scan_enable, scan_reset, select_pins_released, config_complete;
    logic [2:0] latched_mode;
    int mismatches = 0, samples_checked = 0, cycles = 0, rx = 0;
    apcp_if apcp_if_inst ();
    apcp_device #(.CLEAR_CYCLES(4), .CONFIG_BYTES(NB), .FIFO_DEPTH(32)) apcp_device_inst (.core_clk(core_clk),
        .rst(rst), .pins(apcp_if_inst), .cfg_byte(cfg_byte), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
        .scan_selected(scan_sel), .scan_enable(scan_enable), .scan_reset(scan_reset),
        .select_pins_released(select_pins_released), .latched_mode(latched_mode), .config_complete(config_complete));
    apcp_host apcp_host_inst (.core_clk(core_clk), .rst(rst), .pins(apcp_if_inst), .byte_data(byte_data),
        .byte_valid(byte_valid), .byte_ready(byte_ready), .status_req(status_req), .status_valid(status_valid),
        .status_bit(status_bit), .restart_req(restart_req), .hold_init(hold_init), .hold_done(hold_done),
        .device_busy(device_busy), .device_done(device_done));
    apcp_checker apcp_checker_inst (.core_clk(core_clk), .rst(rst), .wr_n(apcp_if_inst.wr_n),
        .rd_n(apcp_if_inst.rd_n), .select_low_n(apcp_if_inst.select_low_n), .select_high(apcp_if_inst.select_high),
        .data_bit_seven(apcp_if_inst.data_bit_seven), .dev_d7_oe(apcp_if_inst.dev_d7_oe),
        .ready_out(apcp_if_inst.ready_out), .config_busy_high_out(apcp_if_inst.config_busy_high_out),
        .config_busy_low_out(apcp_if_inst.config_busy_low_out), .dev_init_oe(apcp_if_inst.dev_init_oe),
        .init_n(apcp_if_inst.init_n), .done(apcp_if_inst.done), .reprogram_n(apcp_if_inst.reprogram_n));
    initial forever #5 core_clk = ~core_clk;
    // ==========================================================
    // compare, drive and close
    task automatic check_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check_bit
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_byte
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic send_byte(input logic [7:0] b);
        byte_data <= b;
        byte_valid <= 1'b1;
        for (int n = 0; n < 400 && byte_ready !== 1'b1; n++) @(negedge core_clk);
        @(posedge core_clk);
        byte_valid <= 1'b0;
        @(posedge core_clk);
    endtask : send_byte
    task automatic read_status(input logic exp);
        status_req <= 1'b1;
        @(posedge core_clk);
        status_req <= 1'b0;
        for (int n = 0; n < 40 && status_valid !== 1'b1; n++) @(negedge core_clk);
        check_bit(status_bit, exp, "status bit");
        @(posedge core_clk);
    endtask : read_status
    always @(posedge core_clk) begin
        cycles++;
        if (!rst && cfg_valid === 1'b1 && cfg_ready) begin
            check_byte(cfg_byte, rx[7:0] + 8'h3C, "drained byte");
            rx++;
        end
        if (cycles == 12000) begin
            mismatches++;
            close_out();
        end
    end
    // ==========================================================
    // scenarios
    task automatic t_init_hold();
        repeat (30) @(posedge core_clk);
        check_bit(apcp_if_inst.ready_out, 1'b0, "ready while init held");
        check_bit(device_busy, 1'b1, "busy high");
        check_bit(apcp_if_inst.config_busy_low_out, 1'b0, "busy low");
        check_bit(apcp_if_inst.tms, 1'b1, "test select held");
        hold_init <= 1'b0;
        for (int n = 0; n < 100 && apcp_if_inst.ready_out !== 1'b1; n++) @(posedge core_clk);
        check_bit(apcp_if_inst.ready_out, 1'b1, "ready after init");
        check_byte({5'h00, latched_mode}, {5'h00, apcp_pkg::MODE_ASYNC_PERIPH}, "mode");
        $display("test init_hold done");
    endtask : t_init_hold
    task automatic t_fill();
        read_status(1'b1);
        for (int i = 0; i < 32; i++) send_byte(8'(i) + 8'h3C);
        repeat (30) @(posedge core_clk);
        check_bit(apcp_if_inst.ready_out, 1'b0, "ready with fifo full");
        read_status(1'b0);
        $display("test fill done");
    endtask : t_fill
    task automatic t_drain();
        hold_done <= 1'b1;
        cfg_ready <= 1'b1;
        for (int n = 0; n < 200 && rx < 32; n++) @(posedge core_clk);
        for (int i = 32; i < NB; i++) send_byte(8'(i) + 8'h3C);
        repeat (60) @(posedge core_clk);
        check_byte(rx[7:0], 8'(NB), "byte count");
        check_bit(config_complete, 1'b0, "held by done");
        hold_done <= 1'b0;
        for (int n = 0; n < 100 && config_complete !== 1'b1; n++) @(posedge core_clk);
        check_bit(device_done, 1'b1, "done seen");
        check_bit(apcp_if_inst.config_busy_high_out, 1'b0, "busy high off");
        check_bit(apcp_if_inst.config_busy_low_out, 1'b1, "busy low off");
        check_bit(select_pins_released, 1'b1, "selects freed");
        check_bit(scan_enable, 1'b0, "scan off");
        scan_sel <= 1'b1;
        repeat (2) @(posedge core_clk);
        check_bit(scan_enable, 1'b1, "scan kept when chosen");
        $display("test drain done");
    endtask : t_drain
    task automatic t_restart();
        restart_req <= 1'b1;
        @(posedge core_clk);
        restart_req <= 1'b0;
        for (int n = 0; n < 40 && scan_reset !== 1'b1; n++) @(posedge core_clk);
        check_bit(scan_reset, 1'b1, "scan reset");
        repeat (20) @(posedge core_clk);
        check_bit(config_complete, 1'b0, "restarted");
        $display("test restart done");
    endtask : t_restart
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_init_hold();
        t_fill();
        t_drain();
        t_restart();
        close_out();
    end
endmodule : apcp_tb_top
